// >>> hw/adc_scan_pkg.sv
// Purpose: Shared constants and carriers for the ADC scan averager.
// Assumes: A 200 MHz system clock.
// Notes:   Cycle counts derive from the times, so a clock change is one edit.
package adc_scan_pkg;
    // =====================================================================
    // Channel map
    localparam int NUM_EXT  = 16;
    localparam int NUM_INT  = 4;
    localparam int NUM_CH   = NUM_EXT + NUM_INT;
    localparam int NUM_ANALOG_OUTPUT_CHANNEL = 4;
    localparam int SAMPLES  = 4;
    localparam int REF_CH   = NUM_EXT;

    // =====================================================================
    // Timing
    localparam int CLK_MHZ      = 200;
    localparam int SCAN_US      = 2000;
    localparam int SCAN_CYC     = SCAN_US * CLK_MHZ;
    localparam int SETTLE_NS    = 2000;
    localparam int SETTLE_CYC   = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_US      = 10;
    localparam int CONV_TMO_CYC = 2 * CONV_US * CLK_MHZ;
    localparam logic [3:0] INTEG_60 = 4'h8;
    localparam logic [3:0] INTEG_50 = 4'ha;
    localparam logic [2:0] WD_SCANS = 3'h4;

    // =====================================================================
    // Reset values and self-test window
    localparam logic [15:0]        RANGE_RST = 16'h0000;
    localparam logic [15:0]        DAC_ZERO  = 16'h0000;
    localparam logic signed [15:0] ST_LO     = 16'sh1000;
    localparam logic signed [15:0] ST_HI     = 16'sh7000;

    // =====================================================================
    // Carriers
    typedef struct packed {
        logic [4:0] mux;
        logic       gain_hi;
    } adc_sel_s;

    typedef struct packed {
        logic [15:0] snap;
        logic [15:0] integ;
    } chan_val_s;
endpackage

// >>> hw/reset_watchdog.sv
// Purpose: Communication and internal watchdogs that reset the module.
// Assumes: scan_tick pulses once per 2 ms scan period.
// Notes:   Both timers count scan ticks, so the interval unit is 2 ms.
`timescale 1ns/1ps
`default_nettype none
module reset_watchdog (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Events
    input  wire logic       scan_tick,
    input  wire logic       scan_kick,
    input  wire logic       gw_activity,
    input  wire logic [7:0] wd_interval,
    // Reset request
    output logic            wd_rst
);
    logic [7:0] comm_cnt_ff;
    logic [2:0] kick_cnt_ff;
    logic       rst_ff;
    wire        comm_exp;
    wire        int_exp;

    // =====================================================================
    // Expiry decode
    // An interval of zero disables the communication watchdog.
    assign comm_exp = (wd_interval != 8'h00) && scan_tick &&
                      ({1'b0, comm_cnt_ff} + 9'h001 >= {1'b0, wd_interval});
    assign int_exp  = scan_tick &&
                      ({1'b0, kick_cnt_ff} + 4'h1 >= {1'b0, adc_scan_pkg::WD_SCANS});
    assign wd_rst   = rst_ff;

    // =====================================================================
    // Counters
    // Counts saturate, so a timer enabled late after a long silence fires at the next scan tick.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            comm_cnt_ff <= 8'h00;
            kick_cnt_ff <= 3'h0;
            rst_ff      <= 1'b0;
        end else begin
            rst_ff <= comm_exp | int_exp;
            if (rst_ff || gw_activity) begin
                comm_cnt_ff <= 8'h00;
            end else if (scan_tick && comm_cnt_ff != 8'hff) begin
                comm_cnt_ff <= comm_cnt_ff + 8'h01;
            end
            if (rst_ff || scan_kick) begin
                kick_cnt_ff <= 3'h0;
            end else if (scan_tick && kick_cnt_ff != 3'h7) begin
                kick_cnt_ff <= kick_cnt_ff + 3'h1;
            end
        end
    end

    // =====================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_comm_expire:
    assert property ((scan_tick && wd_interval == 8'h01) |=> wd_rst)
        else $error("communication time-out did not reset");
    a_int_expire:
    assert property ((scan_tick && !scan_kick && kick_cnt_ff == 3'h3) |=> wd_rst)
        else $error("internal watchdog did not reset");
    a_rst_cause:
    assert property (wd_rst |-> $past(scan_tick))
        else $error("reset raised without a scan tick");
endmodule // reset_watchdog
`default_nettype wire

// >>> hw/multichannel_adc_scan_averager.sv
// Purpose: Scans 16 inputs and internal references every 2 ms and averages.
// Assumes: ADC handshake logic runs on clk; gateway decode is elsewhere.
// Notes:   Snapshot is the mean of four samples; integrated is a line period.
`timescale 1ns/1ps
`default_nettype none
module multichannel_adc_scan_averager #(
    parameter int SCAN_CYC = adc_scan_pkg::SCAN_CYC
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   resetn,
    // Converter
    output adc_scan_pkg::adc_sel_s      adc_sel,
    output logic                        adc_start,
    input  wire logic                   adc_done,
    input  wire logic [15:0]            adc_data,
    // Configuration
    input  wire logic                   line_50hz,
    input  wire logic                   range_wr,
    input  wire logic [15:0]            range_in,
    output logic [15:0]                 range_out,
    // Output setpoints
    input  wire logic                   sp_wr,
    input  wire logic [1:0]             sp_chan,
    input  wire logic [15:0]            sp_value,
    output logic [3:0][15:0]            analog_output_channel_setpoint,
    // Readback
    input  wire logic [4:0]             rd_chan,
    output adc_scan_pkg::chan_val_s     rd_val,
    // Health
    input  wire logic                   gw_activity,
    input  wire logic [7:0]             wd_interval,
    output logic                        module_reset,
    output logic                        scan_busy,
    output logic                        selftest_done,
    output logic                        selftest_fault
);
    localparam int NCH = adc_scan_pkg::NUM_CH;
    localparam int NEX = adc_scan_pkg::NUM_EXT;
    localparam int SCW = $clog2(SCAN_CYC);
    localparam logic [SCW-1:0] SC_LAST  = SCW'(SCAN_CYC - 1);
    localparam logic [11:0]    SET_LAST = 12'(adc_scan_pkg::SETTLE_CYC - 1);
    localparam logic [11:0]    TMO_LAST = 12'(adc_scan_pkg::CONV_TMO_CYC - 1);
    localparam logic [4:0]     CH_LAST  = 5'(NCH - 1);
    localparam logic [4:0]     CH_EXT   = 5'(NEX);
    localparam logic [4:0]     CH_REF   = 5'(adc_scan_pkg::REF_CH);
    localparam logic [2:0]     SMP_LAST = 3'(adc_scan_pkg::SAMPLES - 1);

    typedef enum {S_IDLE, S_SETTLE, S_CONV, S_WAIT, S_STORE} scan_e;

    scan_e                   state_ff;
    logic [SCW-1:0]          scan_cnt_ff;
    logic [4:0]              ch_ff;
    logic [11:0]             tmr_ff;
    logic [2:0]              smp_ff;
    logic signed [17:0]      sum_ff;
    logic                    conv_err_ff;
    logic [15:0]             range_ff;
    logic [NCH-1:0]          fresh_ff;
    logic signed [15:0]      snap_ff  [NEX];
    logic signed [15:0]      integ_ff [NCH];
    logic signed [19:0]      acc_ff   [NCH];
    logic [3:0]              cnt_ff   [NCH];
    logic [3:0][15:0]        sp_ff;
    adc_scan_pkg::adc_sel_s  sel_ff;
    adc_scan_pkg::chan_val_s rd_ff;
    logic                    st_pend_ff;
    logic                    st_fault_ff;

    wire                     scan_tick;
    wire                     scan_kick;
    wire                     wd_rst;
    wire                     store_ok;
    wire                     tmo_hit;
    wire                     st_bad;
    wire signed [15:0]       snap_w;
    wire signed [19:0]       snap_x;
    wire signed [17:0]       data_x;
    wire [3:0]               integ_len;
    wire [NCH-1:0]           range_chg;

    // Signed divide truncates toward zero; a shift would bias negatives.
    function automatic logic [15:0] integ_avg(input logic signed [19:0] acc,
                                              input logic l50);
        logic signed [19:0] q;
        q = l50 ? acc / 20'sd10 : acc / 20'sd8;
        return q[15:0];
    endfunction

    // =====================================================================
    // Decode
    assign scan_tick = scan_cnt_ff == SC_LAST;
    assign scan_kick = state_ff == S_STORE && ch_ff == CH_LAST;
    assign store_ok  = state_ff == S_STORE && !conv_err_ff;
    assign tmo_hit   = state_ff == S_WAIT && !adc_done && tmr_ff == TMO_LAST;
    assign data_x    = {{2{adc_data[15]}}, adc_data};
    assign snap_w    = sum_ff[17:2];
    assign snap_x    = {{4{snap_w[15]}}, snap_w};
    assign integ_len = line_50hz ? adc_scan_pkg::INTEG_50 : adc_scan_pkg::INTEG_60;
    assign range_chg = range_wr ? {4'h0, range_in ^ range_ff} : '0;
    assign st_bad    = st_pend_ff && store_ok && ch_ff == CH_REF &&
                       (snap_w < adc_scan_pkg::ST_LO || snap_w > adc_scan_pkg::ST_HI);
    assign adc_start     = state_ff == S_CONV;
    assign adc_sel       = sel_ff;
    assign range_out     = range_ff;
    assign analog_output_channel_setpoint = sp_ff;
    assign rd_val        = rd_ff;
    assign module_reset  = wd_rst;
    assign scan_busy     = state_ff != S_IDLE;
    assign selftest_done  = !st_pend_ff;
    assign selftest_fault = st_fault_ff;

    // =====================================================================
    // Scan period timer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scan_cnt_ff <= '0;
        end else if (wd_rst || scan_tick) begin
            scan_cnt_ff <= '0;
        end else begin
            scan_cnt_ff <= scan_cnt_ff + SCW'(1);
        end
    end

    // =====================================================================
    // Sequencer
    // A converter that never answers ends the channel with no store.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff    <= S_IDLE;
            ch_ff       <= 5'h00;
            tmr_ff      <= 12'h000;
            smp_ff      <= 3'h0;
            sum_ff      <= '0;
            conv_err_ff <= 1'b0;
        end else if (wd_rst) begin
            state_ff    <= S_IDLE;
            ch_ff       <= 5'h00;
            tmr_ff      <= 12'h000;
            smp_ff      <= 3'h0;
            sum_ff      <= '0;
            conv_err_ff <= 1'b0;
        end else begin
            case (state_ff)
                S_IDLE: if (scan_tick) begin
                    ch_ff    <= 5'h00;
                    tmr_ff   <= 12'h000;
                    state_ff <= S_SETTLE;
                end
                S_SETTLE: begin
                    tmr_ff <= tmr_ff + 12'h001;
                    if (tmr_ff == SET_LAST) begin
                        smp_ff      <= 3'h0;
                        sum_ff      <= '0;
                        conv_err_ff <= 1'b0;
                        state_ff    <= S_CONV;
                    end
                end
                S_CONV: begin
                    tmr_ff   <= 12'h000;
                    state_ff <= S_WAIT;
                end
                S_WAIT: if (adc_done) begin
                    sum_ff   <= sum_ff + data_x;
                    smp_ff   <= smp_ff + 3'h1;
                    state_ff <= (smp_ff == SMP_LAST) ? S_STORE : S_CONV;
                end else if (tmr_ff == TMO_LAST) begin
                    conv_err_ff <= 1'b1;
                    state_ff    <= S_STORE;
                end else begin
                    tmr_ff <= tmr_ff + 12'h001;
                end
                S_STORE: begin
                    tmr_ff <= 12'h000;
                    if (ch_ff == CH_LAST) begin
                        state_ff <= S_IDLE;
                    end else begin
                        ch_ff    <= ch_ff + 5'h01;
                        state_ff <= S_SETTLE;
                    end
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    // =====================================================================
    // Multiplexer and gain select
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sel_ff <= '0;
        end else begin
            sel_ff.mux     <= ch_ff;
            sel_ff.gain_hi <= (ch_ff < CH_EXT) & range_ff[ch_ff[3:0]];
        end
    end

    // =====================================================================
    // Snapshot store, external channels only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NEX; i++) snap_ff[i] <= '0;
        end else begin
            for (int i = 0; i < NEX; i++) begin
                if (wd_rst || range_chg[i]) begin
                    snap_ff[i] <= '0;
                end else if (store_ok && ch_ff == 5'(i)) begin
                    snap_ff[i] <= snap_w;
                end
            end
        end
    end

    // =====================================================================
    // Integration over one line period
    // A range write that changes a channel's bit beats a store of that channel in the same cycle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fresh_ff <= '0;
            for (int i = 0; i < NCH; i++) begin
                integ_ff[i] <= '0;
                acc_ff[i]   <= '0;
                cnt_ff[i]   <= 4'h0;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (wd_rst || range_chg[i]) begin
                    integ_ff[i] <= '0;
                    acc_ff[i]   <= '0;
                    cnt_ff[i]   <= 4'h0;
                    fresh_ff[i] <= range_chg[i] & !wd_rst;
                end else if (store_ok && ch_ff == 5'(i)) begin
                    if (fresh_ff[i]) begin
                        integ_ff[i] <= snap_w;
                        acc_ff[i]   <= '0;
                        cnt_ff[i]   <= 4'h0;
                        fresh_ff[i] <= 1'b0;
                    end else if (cnt_ff[i] + 4'h1 >= integ_len) begin
                        integ_ff[i] <= integ_avg(acc_ff[i] + snap_x, line_50hz);
                        acc_ff[i]   <= '0;
                        cnt_ff[i]   <= 4'h0;
                    end else begin
                        acc_ff[i] <= acc_ff[i] + snap_x;
                        cnt_ff[i] <= cnt_ff[i] + 4'h1;
                    end
                end
            end
        end
    end

    // =====================================================================
    // Ranges, setpoints and readback
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            range_ff <= adc_scan_pkg::RANGE_RST;
            sp_ff    <= {4{adc_scan_pkg::DAC_ZERO}};
            rd_ff    <= '0;
        end else begin
            if (wd_rst) begin
                range_ff <= adc_scan_pkg::RANGE_RST;
                sp_ff    <= {4{adc_scan_pkg::DAC_ZERO}};
            end else begin
                if (range_wr) range_ff <= range_in;
                if (sp_wr) sp_ff[sp_chan] <= sp_value;
            end
            rd_ff.snap  <= (rd_chan < CH_EXT) ? snap_ff[rd_chan[3:0]] : '0;
            rd_ff.integ <= (rd_chan <= CH_LAST) ? integ_ff[rd_chan] : '0;
        end
    end

    // =====================================================================
    // Self-test: the first scan after reset checks the reference channel.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_pend_ff  <= 1'b1;
            st_fault_ff <= 1'b0;
        end else if (wd_rst) begin
            st_pend_ff  <= 1'b1;
            st_fault_ff <= 1'b0;
        end else begin
            if (scan_kick) st_pend_ff <= 1'b0;
            if (tmo_hit || st_bad) st_fault_ff <= 1'b1;
        end
    end

    reset_watchdog u_wd (
        .clk         (clk),
        .resetn      (resetn),
        .scan_tick   (scan_tick),
        .scan_kick   (scan_kick),
        .gw_activity (gw_activity),
        .wd_interval (wd_interval),
        .wd_rst      (wd_rst)
    );

    // =====================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_scan_start:
    assert property ((scan_tick && state_ff == S_IDLE && !wd_rst)
                     |=> (state_ff == S_SETTLE && ch_ff == 5'h00))
        else $error("scan did not start at channel 0");
    a_settle_len:
    assert property ((state_ff == S_CONV && smp_ff == 3'h0) |-> $past(tmr_ff) == SET_LAST)
        else $error("conversion started before settling");
    a_four_conv:
    assert property (store_ok |-> smp_ff == 3'h4)
        else $error("snapshot not built from four samples");
    a_chan_step:
    assert property ((state_ff == S_STORE && ch_ff != CH_LAST && !wd_rst)
                     |=> ch_ff == $past(ch_ff) + 5'h01)
        else $error("channel did not step upward");
    a_gain_sel:
    assert property ((state_ff == S_CONV && ch_ff < CH_EXT && $stable(range_ff))
                     |-> adc_sel.gain_hi == range_ff[ch_ff[3:0]] && adc_sel.mux == ch_ff)
        else $error("wrong gain or channel at conversion");
    a_range_clear:
    assert property ((range_wr && range_in[0] != range_ff[0] && !wd_rst)
                     |=> (snap_ff[0] == 16'sh0000 && integ_ff[0] == 16'sh0000 && fresh_ff[0]))
        else $error("range change did not clear channel 0");
    a_fresh_seed:
    assert property ((store_ok && ch_ff == 5'h00 && fresh_ff[0] && !range_wr && !wd_rst)
                     |=> integ_ff[0] == snap_ff[0])
        else $error("first snapshot did not seed integrated value");
    a_reset_dflt:
    assert property (wd_rst |=> (range_ff == 16'h0000 && analog_output_channel_setpoint == '0))
        else $error("reset defaults not applied");
    a_no_int_snap:
    assert property ((rd_chan >= CH_EXT) |=> rd_val.snap == 16'h0000)
        else $error("internal channel returned a snapshot");
endmodule // multichannel_adc_scan_averager
`default_nettype wire

// >>> verif/adc_model.sv
// Purpose: Behavioural converter with input mux and gain stage.
// Assumes: One start pulse per conversion.
// Notes:   A result encodes mux, gain and sample index, so averages are known.
`timescale 1ns/1ps
`default_nettype none
module adc_model (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   resetn,
    // Converter side
    input  wire adc_scan_pkg::adc_sel_s adc_sel,
    input  wire logic                   adc_start,
    input  wire logic                   slow,
    output logic                        adc_done,
    output logic [15:0]                 adc_data
);
    logic [3:0]  wait_ff;
    logic        busy_ff;
    logic [1:0]  idx_ff;
    wire  [15:0] sample = {1'b0, adc_sel.gain_hi, 1'b1, adc_sel.mux, 6'h00, idx_ff};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_ff  <= 1'b0;
            wait_ff  <= 4'h0;
            idx_ff   <= 2'h0;
            adc_done <= 1'b0;
            adc_data <= 16'h0000;
        end else begin
            adc_done <= 1'b0;
            // Outside a result the data bus toggles, so a stale value never looks valid.
            adc_data <= ~adc_data;
            if (adc_start) begin
                busy_ff <= 1'b1;
                wait_ff <= slow ? 4'h9 : 4'h0;
            end else if (busy_ff && wait_ff == 4'h0) begin
                busy_ff  <= 1'b0;
                adc_done <= 1'b1;
                adc_data <= sample;
                idx_ff   <= idx_ff + 2'h1;
            end else if (busy_ff) begin
                wait_ff <= wait_ff - 4'h1;
            end
        end
    end
endmodule // adc_model
`default_nettype wire

// >>> verif/multichannel_adc_scan_averager_tb.sv
// Purpose: Self-checking bench for the scan averager.
// Assumes: Scan period shortened to 10000 cycles.
// Notes:   Expected mux selections and readbacks are queued and popped by monitors.
`timescale 1ns/1ps
`default_nettype none
module multichannel_adc_scan_averager_tb;
    localparam int SC = 10000;
    logic                    clk, resetn, adc_done, adc_start, line_50hz, range_wr, sp_wr;
    logic                    gw_activity, slow, module_reset, scan_busy, rd_req, rd_seen, busy_d;
    logic                    selftest_done, selftest_fault, f;
    logic [15:0]             adc_data, range_in, sp_value, range_out, r;
    logic [1:0]              sp_chan;
    logic [4:0]              rd_chan;
    logic [7:0]              wd_interval;
    logic [3:0][15:0]        analog_output_channel_setpoint, sp_exp;
    adc_scan_pkg::adc_sel_s  adc_sel;
    adc_scan_pkg::adc_sel_s  sel_q[$];
    adc_scan_pkg::chan_val_s rd_val, e, x;
    adc_scan_pkg::chan_val_s val_q[$];
    logic                    full_q[$];
    int                      err_count, n_tests, cyc, last_rise, n;

    multichannel_adc_scan_averager #(.SCAN_CYC(SC)) dut (.clk, .resetn, .adc_sel, .adc_start,
        .adc_done, .adc_data, .line_50hz, .range_wr, .range_in, .range_out, .sp_wr, .sp_chan,
        .sp_value, .analog_output_channel_setpoint, .rd_chan, .rd_val, .gw_activity, .wd_interval,
        .module_reset, .scan_busy, .selftest_done, .selftest_fault);
    adc_model adc (.clk, .resetn, .adc_sel, .adc_start, .slow, .adc_done, .adc_data);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // =====================================================================
    // Checking helpers
    task chk(input string nm, input logic [31:0] ev, input logic [31:0] gv);
        n_tests++;
        if (gv !== ev) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, ev, gv);
        end
    endtask

    task give_verdict;
        $display("Checks %0d, errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    function automatic logic [15:0] snap(input int c, input logic g);
        return {1'b0, g, 1'b1, c[4:0], 8'h01};
    endfunction

    always @(negedge clk) begin
        if (adc_start && sel_q.size() > 0) begin
            chk("adc_sel", {26'h0, sel_q.pop_front()}, {26'h0, adc_sel});
        end
        if (rd_seen) begin
            f = full_q.pop_front();
            e = val_q.pop_front();
            chk("rd_val", f ? e : {e.snap, 16'h0}, f ? rd_val : {rd_val.snap, 16'h0});
        end
    end

    always @(posedge clk) begin
        rd_seen <= rd_req;
        cyc <= cyc + 1;
        busy_d <= scan_busy;
        if (module_reset) last_rise <= 0;
        else if (scan_busy && !busy_d) begin
            if (last_rise != 0) chk("period", SC, cyc - last_rise);
            last_rise <= cyc;
        end
    end

    // =====================================================================
    // Drivers
    task rd(input int c, input adc_scan_pkg::chan_val_s ev, input logic full);
        @(posedge clk);
        #1 rd_chan = c[4:0];
        rd_req = 1'b1;
        val_q.push_back(ev);
        full_q.push_back(full);
        @(posedge clk);
        #1 rd_req = 1'b0;
    endtask

    task exp_scan(input logic [15:0] rg);
        for (int c = 0; c < 20; c++) repeat (4) sel_q.push_back({c[4:0], c < 16 ? rg[c] : 1'b0});
    endtask

    task wait_scan;
        n = 0;
        while (!scan_busy && n < 2 * SC) begin
            @(posedge clk);
            #1 n++;
        end
        while (scan_busy && n < 2 * SC) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 2 * SC) begin
            err_count++;
            give_verdict();
        end
    endtask

    // =====================================================================
    // Main sequence
    initial begin
        {resetn, range_wr, sp_wr, rd_req, slow, range_in, sp_value, sp_chan, rd_chan} = '0;
        wd_interval = 8'h00;
        gw_activity = 1'b1;
        void'($urandom(32'hd994));
        line_50hz = 1'($urandom);
        repeat (10) @(posedge clk);
        #1 resetn = 1'b1;
        chk("range_out", 0, range_out);
        for (int i = 0; i < 4; i++) chk("setpoint", 0, analog_output_channel_setpoint[i]);
        exp_scan(16'h0000);
        wait_scan();
        chk("selftest", 2'b10, {selftest_done, selftest_fault});
        for (int c = 0; c < 16; c++) rd(c, {snap(c, 1'b0), 16'h0}, 1'b0);
        rd(16, 32'h0, 1'b0);
        r = 16'($urandom) | 16'h8001;
        slow = 1'($urandom);
        @(posedge clk);
        // Set bits stand for thermocouple inputs, clear bits for current-loop inputs.
        #1 range_in = r;
        range_wr = 1'b1;
        @(posedge clk);
        #1 range_wr = 1'b0;
        chk("range_out", r, range_out);
        for (int c = 0; c < 16; c++) if (r[c]) rd(c, 32'h0, 1'b1);
        exp_scan(r);
        wait_scan();
        for (int c = 0; c < 16; c++) rd(c, {snap(c, r[c]), snap(c, r[c])}, r[c]);
        chk("sel_q", 0, sel_q.size());
        repeat (6) begin
            exp_scan(r);
            wait_scan();
        end
        // Unchanged channels now hold eight snapshots since reset; at 50 Hz ten are needed.
        for (int c = 0; c < 20; c++) begin
            x.snap  = c < 16 ? snap(c, r[c]) : 16'h0;
            x.integ = (c < 16 && r[c]) ? snap(c, 1'b1) : line_50hz ? 16'h0 : snap(c, 1'b0);
            rd(c, x, 1'b1);
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            #1 sp_wr = 1'b1;
            sp_chan = i[1:0];
            sp_value = 16'($urandom);
            sp_exp[i] = sp_value;
        end
        @(posedge clk);
        #1 sp_wr = 1'b0;
        for (int i = 0; i < 4; i++) chk("setpoint", sp_exp[i], analog_output_channel_setpoint[i]);
        wd_interval = 8'h01;
        gw_activity = 1'b0;
        n = 0;
        while (module_reset !== 1'b1 && n < 3 * SC) begin
            @(posedge clk);
            #1 n++;
        end
        chk("wd_reset", 1, module_reset);
        @(posedge clk);
        #1 chk("range_out", 0, range_out);
        for (int i = 0; i < 4; i++) chk("setpoint", 0, analog_output_channel_setpoint[i]);
        chk("selftest_done", 0, selftest_done);
        give_verdict();
    end
endmodule // multichannel_adc_scan_averager_tb
`default_nettype wire
